// ===== agc_debounce_gain.sv
// axi4-lite register block for agc debounce timing and gain readback
`timescale 1ns/100ps
`default_nettype none
module agc_debounce_gain
    import agc_pkg::*;
#(
    parameter int unsigned ADDR_W   = 12,
    parameter int unsigned TICK_DIV = WORD_DIV
)
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              level_below_noise,
    input  wire logic [GAIN_W-1:0] agc_gain_in,
    output logic                   noise_gated,
    output logic                   word_tick
);
    agc_dbnc_if dbnc ();

    logic [NOISE_DBNC_W-1:0]  noise_dbnc_reg;
    logic [SIGNAL_DBNC_W-1:0] signal_dbnc_reg;
    logic [NOISE_THR_W-1:0]   noise_thr_reg;
    logic [GAIN_W-1:0]        gain_reg;
    logic [GAIN_W-1:0]        gain_next;
    logic [15:0]              div_reg;
    logic                     tick_reg;

    logic                     aw_hold_reg;
    logic [7:0]               aw_idx_reg;
    logic                     w_hold_reg;
    logic [7:0]               w_data_reg;
    logic                     w_strb_reg;
    logic                     bvalid_reg;
    logic [1:0]               bresp_reg;
    logic                     rvalid_reg;
    logic [31:0]              rdata_reg;
    logic [1:0]               rresp_reg;
    logic [7:0]               ar_idx;
    logic                     do_write;
    logic                     idx_known;
    logic [7:0]               rd_byte;

    function automatic logic [CNT_W-1:0] noise_ticks_of(input logic [NOISE_DBNC_W-1:0] c);
        if (c <= 5'h01)
            return '0;
        else if (c <= 5'h03)
            return CNT_W'(1) << c;
        else if (c <= NOISE_POW_LAST)
            return CNT_W'(1) << (c + 5'h01);
        else if (c == NOISE_SAT_CODE)
            return NOISE_SAT_TICKS;
        else
            return CNT_W'(CNT_W'(c - NOISE_MULT_OFS) * NOISE_BASE);
    endfunction

    function automatic logic [CNT_W-1:0] signal_ticks_of(input logic [SIGNAL_DBNC_W-1:0] c);
        if (c <= 4'h1)
            return '0;
        else if (c <= 4'h3)
            return CNT_W'(1) << c;
        else if (c <= SIGNAL_POW_LAST)
            return CNT_W'(1) << (c + 4'h1);
        else
            return CNT_W'(CNT_W'(c - SIGNAL_MULT_OFS) * SIGNAL_BASE);
    endfunction

    // word clock enable
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end
        else if (div_reg == 16'(TICK_DIV - 1))
        begin
            div_reg  <= '0;
            tick_reg <= 1'b1;
        end
        else
        begin
            div_reg  <= div_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    assign word_tick         = tick_reg;
    assign dbnc.word_tick    = tick_reg;
    assign dbnc.below_noise  = level_below_noise;
    assign dbnc.gate_en      = (noise_thr_reg != '0);
    assign dbnc.noise_ticks  = noise_ticks_of(noise_dbnc_reg);
    assign dbnc.signal_ticks = signal_ticks_of(signal_dbnc_reg);
    assign noise_gated       = dbnc.gated;

    agc_dbnc_timer agc_dbnc_timer_inst (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .dbnc    (dbnc)
    );

    // applied gain, clamped to the reportable span
    always_comb
    begin
        if ($signed(agc_gain_in) < $signed(GAIN_MIN))
            gain_next = GAIN_MIN;
        else if ($signed(agc_gain_in) > $signed(GAIN_MAX))
            gain_next = GAIN_MAX;
        else
            gain_next = agc_gain_in;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            gain_reg <= GAIN_RST;
        else
            gain_reg <= gain_next;
    end

    // write channel
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign do_write      = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            aw_hold_reg <= 1'b0;
            aw_idx_reg  <= 8'h00;
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 8'h00;
            w_strb_reg  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                aw_idx_reg  <= 8'(s_axi_awaddr[ADDR_W-1:2]);
            end
            else if (do_write)
            begin
                aw_hold_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_strb_reg <= s_axi_wstrb[0];
            end
            else if (do_write)
            begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    function automatic logic known_idx(input logic [7:0] i);
        return (i == IDX_NOISE_DBNC) || (i == IDX_SIGNAL_DBNC) ||
               (i == IDX_APPLIED_GAIN) || (i == IDX_NOISE_THR);
    endfunction

    assign idx_known = known_idx(aw_idx_reg);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= idx_known ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    // control registers; upper reserved bits are not stored
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            noise_dbnc_reg  <= NOISE_DBNC_RST;
            signal_dbnc_reg <= SIGNAL_DBNC_RST;
            noise_thr_reg   <= NOISE_THR_RST;
        end
        else if (do_write && w_strb_reg)
        begin
            if (aw_idx_reg == IDX_NOISE_DBNC)
                noise_dbnc_reg <= w_data_reg[NOISE_DBNC_W-1:0];
            if (aw_idx_reg == IDX_SIGNAL_DBNC)
                signal_dbnc_reg <= w_data_reg[SIGNAL_DBNC_W-1:0];
            if (aw_idx_reg == IDX_NOISE_THR)
                noise_thr_reg <= w_data_reg[NOISE_THR_W-1:0];
        end
    end

    // read channel
    assign ar_idx        = 8'(s_axi_araddr[ADDR_W-1:2]);
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_comb
    begin
        rd_byte = 8'h00;
        if (ar_idx == IDX_NOISE_DBNC)
            rd_byte = {3'h0, noise_dbnc_reg};
        else if (ar_idx == IDX_SIGNAL_DBNC)
            rd_byte = {4'h0, signal_dbnc_reg};
        else if (ar_idx == IDX_APPLIED_GAIN)
            rd_byte = gain_reg;
        else if (ar_idx == IDX_NOISE_THR)
            rd_byte = {3'h0, noise_thr_reg};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h00_0000, rd_byte};
            rresp_reg  <= known_idx(ar_idx) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    a_gain_in_span: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $signed(gain_reg) >= $signed(GAIN_MIN) && $signed(gain_reg) <= $signed(GAIN_MAX))
        else $error("applied gain outside reportable span");

    a_gain_after_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(rst_n) |-> gain_reg == 8'h00)
        else $error("applied gain not zero after reset");

    a_noise_zero_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
        noise_dbnc_reg == 5'h01 |-> dbnc.noise_ticks == 17'h00000)
        else $error("noise code one is not zero delay");

    a_noise_pow_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
        noise_dbnc_reg == 5'h0b |-> dbnc.noise_ticks == 17'h01000)
        else $error("noise code eleven is not 4096");

    a_noise_mult_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        noise_dbnc_reg >= 5'h0c && noise_dbnc_reg <= 5'h1e
        |-> dbnc.noise_ticks == 17'((noise_dbnc_reg - 5'h0a) * 17'h01000))
        else $error("noise multiple code wrong");

    a_noise_saturate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        noise_dbnc_reg == 5'h1f |-> dbnc.noise_ticks == 17'h14000)
        else $error("noise code 31 does not saturate");

    a_signal_pow_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
        signal_dbnc_reg == 4'ha |-> dbnc.signal_ticks == 17'h00800)
        else $error("signal code ten is not 2048");

    a_signal_mult_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        signal_dbnc_reg >= 4'hb
        |-> dbnc.signal_ticks == 17'((signal_dbnc_reg - 4'h9) * 17'h00800))
        else $error("signal multiple code wrong");

    a_gate_disabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
        noise_thr_reg == 5'h00 |=> !noise_gated)
        else $error("noise gate active while threshold is zero");
endmodule
`default_nettype wire

// ===== agc_pkg.sv
// constants for the left-channel agc debounce and gain readback block
// How it works
// - noise debounce is five bits; code 1 means zero delay
// - noise codes 2 and 3 give 4 and 8 word clocks; codes 4 to 11 give 32, doubling to 4096
// - noise codes 12 to 30 give 2 to 20 times 4096 word clocks
// - noise code 31 stays at 20 times 4096 word clocks
// - signal debounce is four bits; 1 is zero, 2 and 3 give 4 and 8, 4 to 10 give 32 doubling up to 2048
// - signal codes 11 to 15 give 2 to 6 times 2048 word clocks
// - applied gain reads as signed half-decibel steps from -12 to 58 dB
// - applied gain reads zero after reset
// - noise threshold zero turns the noise gate off
package agc_pkg;
    localparam int unsigned SYS_CLK_HZ     = 50_000_000;
    localparam int unsigned WORD_CLK_HZ    = 48_000;
    localparam int unsigned WORD_DIV       = SYS_CLK_HZ / WORD_CLK_HZ;

    localparam logic [7:0]  IDX_NOISE_DBNC  = 8'h5b;
    localparam logic [7:0]  IDX_SIGNAL_DBNC = 8'h5c;
    localparam logic [7:0]  IDX_APPLIED_GAIN = 8'h5d;
    localparam logic [7:0]  IDX_NOISE_THR   = 8'h57;

    localparam int unsigned NOISE_DBNC_W   = 5;
    localparam int unsigned SIGNAL_DBNC_W  = 4;
    localparam int unsigned NOISE_THR_W    = 5;
    localparam int unsigned GAIN_W         = 8;
    localparam int unsigned CNT_W          = 17;

    localparam logic [NOISE_DBNC_W-1:0]  NOISE_DBNC_RST  = 5'h00;
    localparam logic [SIGNAL_DBNC_W-1:0] SIGNAL_DBNC_RST = 4'h0;
    localparam logic [NOISE_THR_W-1:0]   NOISE_THR_RST   = 5'h00;
    localparam logic [GAIN_W-1:0]        GAIN_RST        = 8'h00;
    localparam logic [GAIN_W-1:0]        GAIN_MIN        = 8'he8;
    localparam logic [GAIN_W-1:0]        GAIN_MAX        = 8'h74;

    localparam logic [NOISE_DBNC_W-1:0]  NOISE_POW_LAST  = 5'h0b;
    localparam logic [NOISE_DBNC_W-1:0]  NOISE_MULT_OFS  = 5'h0a;
    localparam logic [NOISE_DBNC_W-1:0]  NOISE_SAT_CODE  = 5'h1f;
    localparam logic [SIGNAL_DBNC_W-1:0] SIGNAL_POW_LAST = 4'ha;
    localparam logic [SIGNAL_DBNC_W-1:0] SIGNAL_MULT_OFS = 4'h9;
    localparam logic [CNT_W-1:0]         NOISE_BASE      = 17'h01000;
    localparam logic [CNT_W-1:0]         NOISE_SAT_TICKS = 17'h14000;
    localparam logic [CNT_W-1:0]         SIGNAL_BASE     = 17'h00800;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== agc_dbnc_if.sv
// signals between the register front end and the debounce timer
`timescale 1ns/100ps
`default_nettype none
interface agc_dbnc_if;
    import agc_pkg::*;
    logic                word_tick;
    logic                below_noise;
    logic                gate_en;
    logic [CNT_W-1:0]    noise_ticks;
    logic [CNT_W-1:0]    signal_ticks;
    logic                gated;
    modport ctrl  (output word_tick, below_noise, gate_en, noise_ticks, signal_ticks,
                   input gated);
    modport timer (input word_tick, below_noise, gate_en, noise_ticks, signal_ticks,
                   output gated);
endinterface
`default_nettype wire

// ===== agc_dbnc_timer.sv
// noise gate debounce timer counted in word clocks
`timescale 1ns/100ps
`default_nettype none
module agc_dbnc_timer
    import agc_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    agc_dbnc_if.timer   dbnc
);
    logic             gated_reg;
    logic [CNT_W-1:0] hold_reg;
    logic [CNT_W-1:0] target;

    assign target     = gated_reg ? dbnc.signal_ticks : dbnc.noise_ticks;
    assign dbnc.gated = gated_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            gated_reg <= 1'b0;
            hold_reg  <= '0;
        end
        else if (!dbnc.gate_en)
        begin
            gated_reg <= 1'b0;
            hold_reg  <= '0;
        end
        else if (dbnc.below_noise == gated_reg)
        begin
            hold_reg <= '0;
        end
        else if (target == '0)
        begin
            gated_reg <= dbnc.below_noise;
            hold_reg  <= '0;
        end
        else if (dbnc.word_tick)
        begin
            if (hold_reg + CNT_W'(1) >= target)
            begin
                gated_reg <= dbnc.below_noise;
                hold_reg  <= '0;
            end
            else
            begin
                hold_reg <= hold_reg + CNT_W'(1);
            end
        end
    end

    a_gate_hold_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(gated_reg) && $past(dbnc.gate_en) && $past(target) != '0
        |-> $past(dbnc.word_tick) && $past(hold_reg) + CNT_W'(1) >= $past(target))
        else $error("gate state changed before debounce time elapsed");
endmodule
`default_nettype wire

// ===== agc_debounce_gain_bench.sv
// self-checking bench for the agc debounce and gain readback block
`timescale 1ns/100ps
`default_nettype none
module agc_debounce_gain_bench;
    import agc_pkg::*;
    localparam logic [11:0] A_NOISE = {2'b00, IDX_NOISE_DBNC, 2'b00};
    localparam logic [11:0] A_SIG   = {2'b00, IDX_SIGNAL_DBNC, 2'b00};
    localparam logic [11:0] A_GAIN  = {2'b00, IDX_APPLIED_GAIN, 2'b00};
    localparam logic [11:0] A_THR   = {2'b00, IDX_NOISE_THR, 2'b00};
    localparam int          LIMIT   = 80000;
    localparam int          TDIV    = 4;
    logic              clk_sys = 1'b0;
    logic              rst_n   = 1'b0;
    logic [11:0]       awaddr  = 12'h000;
    logic [11:0]       araddr  = 12'h000;
    logic [31:0]       wdata   = 32'h0;
    logic [3:0]        wstrb   = 4'hf;
    logic              awvalid = 1'b0;
    logic              wvalid  = 1'b0;
    logic              bready  = 1'b0;
    logic              arvalid = 1'b0;
    logic              rready  = 1'b0;
    logic              level   = 1'b0;
    logic [7:0]        gain_in = 8'h00;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic              arready;
    logic              rvalid;
    logic              gated;
    logic              tick;
    logic [1:0]        bresp;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [7:0]        g;
    logic [7:0]        edges [4] = '{8'he8, 8'he7, 8'h74, 8'h75};
    int                ncode [6] = '{0, 1, 2, 3, 4, 12};
    int                scode [6] = '{0, 2, 3, 4, 1, 11};
    int unsigned       mdl [logic [11:0]];
    int                fails = 0;
    int                n_compared = 0;
    int                cycles = 0;
    int                seed = 1367;
    int                i;
    int                n;

    agc_debounce_gain #(.ADDR_W(12), .TICK_DIV(TDIV)) agc_debounce_gain_inst (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .level_below_noise(level),
        .agc_gain_in(gain_in), .noise_gated(gated), .word_tick(tick)
    );

    always #10 clk_sys = ~clk_sys;

    function automatic int dly(input bit noise, input int c);
        if (c < 2) return 0;
        if (c < 4) return 4 << (c - 2);
        if (c <= (noise ? 11 : 10)) return 1 << (c + 1);
        if (noise) return ((c > 30 ? 30 : c) - 10) * 4096;
        return (c - 9) * 2048;
    endfunction

    function automatic logic [7:0] clamp(input logic [7:0] v);
        int s;
        s = $signed(v);
        if (s < -24) return GAIN_MIN;
        if (s > 116) return GAIN_MAX;
        return v;
    endfunction

    task automatic conclude();
        begin
            $display("compared %0d, mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_compared++;
            if (seen !== exp)
            begin
                fails++;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge clk_sys);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do
            begin
                @(posedge clk_sys);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while ((awvalid && !awready) || (wvalid && !wready));
            do @(posedge clk_sys); while (bvalid !== 1'b1);
            bready <= 1'b0;
            check(bresp, mdl.exists(a) ? RESP_OKAY : RESP_SLVERR);
            if (a != A_GAIN && mdl.exists(a) && wstrb[0]) mdl[a] = d & (a == A_SIG ? 32'h0f : 32'h1f);
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        begin
            @(posedge clk_sys);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do @(posedge clk_sys); while (arready !== 1'b1);
            arvalid <= 1'b0;
            do @(posedge clk_sys); while (rvalid !== 1'b1);
            rready <= 1'b0;
            check(rdata, e);
            check(rresp, mdl.exists(a) ? RESP_OKAY : RESP_SLVERR);
        end
    endtask

    // change level just after a tick, then count ticks until the gate follows
    task automatic settle(input logic lvl, input int exp_ticks);
        int cnt;
        begin
            cnt = 0;
            do
            begin
                @(posedge clk_sys);
                #1;
            end while (tick !== 1'b1);
            @(posedge clk_sys);
            level <= lvl;
            #1;
            while (gated !== lvl)
            begin
                cnt += (tick === 1'b1);
                @(posedge clk_sys);
                #1;
            end
            check(cnt, exp_ticks);
        end
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fails++;
            conclude();
        end
    end

    initial
    begin
        mdl[A_NOISE] = 0;
        mdl[A_SIG] = 0;
        mdl[A_GAIN] = 0;
        mdl[A_THR] = 0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(A_NOISE, 32'h0);
        rd_chk(A_SIG, 32'h0);
        rd_chk(A_GAIN, {24'h0, GAIN_RST});
        $display("test reset values done");
        axi_wr(A_NOISE, 32'h1f);
        rd_chk(A_NOISE, mdl[A_NOISE]);
        axi_wr(A_SIG, 32'h0f);
        rd_chk(A_SIG, mdl[A_SIG]);
        wstrb <= 4'h0;
        axi_wr(A_NOISE, 32'h03);
        wstrb <= 4'hf;
        rd_chk(A_NOISE, 32'h1f);
        axi_wr(A_GAIN, 32'h55);
        rd_chk(A_GAIN, {24'h0, clamp(gain_in)});
        axi_wr(12'h000, 32'h1);
        rd_chk(12'h000, 32'h0);
        for (i = 0; i < 32; i++)
        begin
            axi_wr(A_NOISE, i);
            rd_chk(A_NOISE, i);
            if (i < 16)
            begin
                axi_wr(A_SIG, i);
                rd_chk(A_SIG, i);
            end
        end
        $display("test register access done");
        do
        begin
            @(posedge clk_sys);
            #1;
        end while (tick !== 1'b1);
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (tick !== 1'b1);
        check(n, TDIV);
        @(posedge clk_sys);
        $display("test word clock done");
        for (i = 0; i < 16; i++)
        begin
            g = (i < 4) ? edges[i] : 8'($random(seed));
            gain_in <= g;
            rd_chk(A_GAIN, {24'h0, clamp(g)});
        end
        $display("test gain readback done");
        axi_wr(A_THR, 32'h1);
        for (i = 0; i < 6; i++)
        begin
            axi_wr(A_NOISE, ncode[i]);
            axi_wr(A_SIG, scode[i]);
            settle(1'b1, dly(1'b1, ncode[i]));
            settle(1'b0, dly(1'b0, scode[i]));
        end
        $display("test debounce times done");
        axi_wr(A_NOISE, 32'h3);
        level <= 1'b1;
        repeat (20) @(posedge clk_sys);
        level <= 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
        check(gated, 1'b0);
        settle(1'b1, dly(1'b1, 3));
        $display("test interrupted debounce done");
        axi_wr(A_THR, 32'h0);
        repeat (40) @(posedge clk_sys);
        #1;
        check(gated, 1'b0);
        $display("test gate disable done");
        conclude();
    end
endmodule
`default_nettype wire
